// ===== rtl/bcbn_addr_gen.sv
// effective file register address for byte and bit instructions
`timescale 1ns/1ps
`default_nettype none
module bcbn_addr_gen (
  input wire logic [7:0] regField,     // f field
  input wire logic accessBit,          // a field
  input wire logic extEnable,          // extended set enabled
  input wire logic [3:0] bankSelect,   // bank select register
  input wire logic [11:0] indexBase,   // index pointer for offset mode
  output logic [11:0] effAddr,         // resolved address
  output logic indexedMode             // offset mode used
);

  // pick access bank, banked or indexed literal offset
  always_comb
  begin
    indexedMode = 1'b0;
    if (!accessBit && extEnable && regField <= bcbn_pkg::IDX_LIMIT)
    begin
      indexedMode = 1'b1;
      effAddr = indexBase + {4'h0, regField};
    end
    else if (!accessBit)
    begin
      if (regField < bcbn_pkg::ACC_SPLIT)
        effAddr = {4'h0, regField};
      else
        effAddr = {bcbn_pkg::ACC_HI_BANK, regField};
    end
    else
      effAddr = {bankSelect, regField};
  end

endmodule : bcbn_addr_gen
`default_nettype wire

// ===== rtl/bcbn_decoder.sv
// decoder and executor for bit clear and branch on negative
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - opcode 1001 clears only bit b of register f
// - a=0 with extended set and f up to 5Fh uses indexed offset
// - upper byte e6 branches only when negative flag is one
// - target is incremented pc plus twice signed 8-bit offset
// - a=0 picks access bank, a=1 uses bank select register
// - taken branch takes two cycles, second a no operation
module bcbn_decoder (
  input wire logic sys_clk,                 // core clock
  input wire logic sys_rst,                 // sync reset, high
  input wire logic instrValid,              // word valid at cycle start
  input wire logic [15:0] instrWord,        // fetched instruction
  input wire logic [20:0] pcIncr,           // pc already incremented
  input wire logic negFlag,                 // negative status flag
  input wire logic extEnable,               // extended set enabled
  input wire logic [3:0] bankSelect,        // bank select register
  input wire logic [11:0] indexBase,        // index pointer
  input wire logic [7:0] regRdData,         // register read data
  output logic [11:0] regRdAddr,            // register read address
  output logic regRdEn,                     // read strobe in Q3
  output bcbn_pkg::bcbn_wr_s regWr,         // write, built in Q4, out in next Q1
  output bcbn_pkg::bcbn_pcw_s pcWr,         // pc write, built in Q4, out in next Q1
  output logic flushNop,                    // nop cycle in progress
  output logic cycleEnd,                    // instruction cycle done
  output logic [1:0] phase                  // current phase
);

  bcbn_pkg::bcbn_phase_e phase_reg, phase_next;
  logic nopCycle_reg, nopCycle_next;
  logic isClr_reg, isClr_next;
  logic isBr_reg, isBr_next;
  logic [15:0] word_reg, word_next;
  logic [11:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;
  logic [20:0] target_reg, target_next;
  logic taken_reg, taken_next;
  logic [11:0] rdAddr_reg, rdAddr_next;
  logic rdEn_reg, rdEn_next;
  bcbn_pkg::bcbn_wr_s wr_reg, wr_next;
  bcbn_pkg::bcbn_pcw_s pcw_reg, pcw_next;
  logic end_reg, end_next;
  logic [11:0] effAddr;
  logic [7:0] mask;
  logic [20:0] offs;

  // resolve file address from the latched word
  bcbn_addr_gen u_addr (
    .regField(word_reg[bcbn_pkg::REG_HI:bcbn_pkg::REG_LO]),
    .accessBit(word_reg[bcbn_pkg::ACC_POS]),
    .extEnable(extEnable),
    .bankSelect(bankSelect),
    .indexBase(indexBase),
    .effAddr(effAddr),
    .indexedMode()
  );

  // single-bit clear mask and sign-extended doubled offset
  always_comb
  begin
    mask = ~(8'h01 << word_reg[bcbn_pkg::BIT_HI:bcbn_pkg::BIT_LO]);
    offs = {{12{word_reg[7]}}, word_reg[7:0], 1'b0};
  end

  // four-phase sequencer; a taken branch books one nop cycle
  always_comb
  begin
    phase_next = phase_reg;
    nopCycle_next = nopCycle_reg;
    unique case (phase_reg)
      bcbn_pkg::PH_Q1:
        phase_next = bcbn_pkg::PH_Q2;
      bcbn_pkg::PH_Q2:
        phase_next = bcbn_pkg::PH_Q3;
      bcbn_pkg::PH_Q3:
        phase_next = bcbn_pkg::PH_Q4;
      bcbn_pkg::PH_Q4:
      begin
        // nop flag spans exactly one whole instruction cycle
        phase_next = bcbn_pkg::PH_Q1;
        nopCycle_next = isBr_reg && taken_reg;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      phase_reg <= bcbn_pkg::PH_Q1;
      nopCycle_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      nopCycle_reg <= nopCycle_next;
    end
  end

  // operand and result latches, one step in each of Q1 to Q3
  always_comb
  begin
    isClr_next = isClr_reg;
    isBr_next = isBr_reg;
    word_next = word_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    target_next = target_reg;
    taken_next = taken_reg;
    unique case (phase_reg)
      bcbn_pkg::PH_Q1:
      begin
        // decode; a word offered in a nop cycle is dropped
        if (nopCycle_reg)
        begin
          isClr_next = 1'b0;
          isBr_next = 1'b0;
        end
        else
        begin
          word_next = instrWord;
          isClr_next = instrValid &&
            instrWord[bcbn_pkg::OPC_HI:bcbn_pkg::OPC_LO] ==
            bcbn_pkg::BCLR_OPC;
          isBr_next = instrValid &&
            instrWord[15:8] == bcbn_pkg::BNEG_OPC;
        end
      end
      bcbn_pkg::PH_Q2:
      begin
        // address resolved; flag looked at once, here
        addr_next = effAddr;
        taken_next = isBr_reg && negFlag;
      end
      bcbn_pkg::PH_Q3:
      begin
        // process data; target built even when not taken
        data_next = regRdData & mask;
        target_next = pcIncr + offs;
      end
      bcbn_pkg::PH_Q4:
      begin
        // nothing latched; results leave via output registers
      end
    endcase
  end

  // operand and result registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      isClr_reg <= 1'b0;
      isBr_reg <= 1'b0;
      word_reg <= 16'h0000;
      addr_reg <= 12'h000;
      data_reg <= 8'h00;
      target_reg <= bcbn_pkg::PC_RESET;
      taken_reg <= 1'b0;
    end
    else
    begin
      isClr_reg <= isClr_next;
      isBr_reg <= isBr_next;
      word_reg <= word_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      target_reg <= target_next;
      taken_reg <= taken_next;
    end
  end

  // strobes drop back every cycle so each stands one cycle only
  always_comb
  begin
    rdAddr_next = rdAddr_reg;
    rdEn_next = 1'b0;
    wr_next = '0;
    pcw_next = '0;
    end_next = 1'b0;
    if (phase_reg == bcbn_pkg::PH_Q2 && isClr_reg)
    begin
      rdAddr_next = effAddr;
      rdEn_next = 1'b1;
    end
    if (phase_reg == bcbn_pkg::PH_Q4)
    begin
      // write destination; no status flag is ever written
      end_next = 1'b1;
      if (isClr_reg)
      begin
        wr_next.valid = 1'b1;
        wr_next.addr = addr_reg;
        wr_next.data = data_reg;
      end
      if (isBr_reg && taken_reg)
      begin
        pcw_next.valid = 1'b1;
        pcw_next.target = target_reg;
      end
    end
  end

  // output registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rdAddr_reg <= 12'h000;
      rdEn_reg <= 1'b0;
      wr_reg <= '0;
      pcw_reg <= '0;
      end_reg <= 1'b0;
    end
    else
    begin
      rdAddr_reg <= rdAddr_next;
      rdEn_reg <= rdEn_next;
      wr_reg <= wr_next;
      pcw_reg <= pcw_next;
      end_reg <= end_next;
    end
  end

  // outputs straight from flip-flops
  assign regRdAddr = rdAddr_reg;
  assign regRdEn = rdEn_reg;
  assign regWr = wr_reg;
  assign pcWr = pcw_reg;
  assign flushNop = nopCycle_reg;
  assign cycleEnd = end_reg;
  assign phase = phase_reg;

endmodule : bcbn_decoder
`default_nettype wire

// ===== rtl/bcbn_pkg.sv
// shared constants and carriers for the bit clear and branch decoder
package bcbn_pkg;

  // opcode matching
  localparam logic [3:0] BCLR_OPC = 4'h9;       // top nibble, bit clear
  localparam logic [7:0] BNEG_OPC = 8'he6;      // upper byte, branch negative
  // instruction field positions
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 12;
  localparam int BIT_HI = 11;
  localparam int BIT_LO = 9;
  localparam int ACC_POS = 8;
  localparam int REG_HI = 7;
  localparam int REG_LO = 0;
  // indexed literal offset limit (95)
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  // access bank split: 00h-5Fh from bank 0, 60h-FFh from bank 0f
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  // phase count of one instruction cycle
  localparam int PHASES = 4;
  // reset values
  localparam logic [20:0] PC_RESET = 21'h000000;

  // register file write request
  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [7:0] data;
  } bcbn_wr_s;

  // program counter write request
  typedef struct packed {
    logic valid;
    logic [20:0] target;
  } bcbn_pcw_s;

  // phase of the instruction cycle
  typedef enum logic [1:0] {
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } bcbn_phase_e;

endpackage : bcbn_pkg

// ===== test/bcbn_decoder_assertions.sv
// checker for the bit clear and branch decoder ports
`timescale 1ns/1ps
`default_nettype none
module bcbn_decoder_assertions (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic [11:0] regRdAddr, // read address
  input wire logic regRdEn, // read strobe
  input wire bcbn_pkg::bcbn_wr_s regWr, // file write
  input wire bcbn_pkg::bcbn_pcw_s pcWr, // pc write
  input wire logic flushNop, // nop cycle
  input wire logic cycleEnd, // cycle done
  input wire logic [1:0] phase // phase
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // read, write and nop cycle timing
  property p_rd; regRdEn |-> phase == 2'h2 && !flushNop; endproperty
  a_rd: assert property (p_rd) else $error("read off phase");
  property p_rdwr; regRdEn |-> ##2 regWr.valid && cycleEnd; endproperty
  a_rdwr: assert property (p_rdwr) else $error("no write");
  property p_addr; regWr.valid |-> regWr.addr == $past(regRdAddr, 2); endproperty
  a_addr: assert property (p_addr) else $error("write addr");
  property p_wrph; regWr.valid || pcWr.valid |-> cycleEnd; endproperty
  a_wrph: assert property (p_wrph) else $error("write off end");
  property p_excl; !(regWr.valid && pcWr.valid); endproperty
  a_excl: assert property (p_excl) else $error("two writes");
  property p_pcfl; pcWr.valid |-> flushNop && !regRdEn; endproperty
  a_pcfl: assert property (p_pcfl) else $error("no nop");
  property p_flen; $rose(flushNop) |-> flushNop[*4] ##1 !flushNop; endproperty
  a_flen: assert property (p_flen) else $error("nop length");
  property p_ce; cycleEnd |-> phase == 2'h0 && $past(phase) == 2'h3; endproperty
  a_ce: assert property (p_ce) else $error("cycle end");
  // main scenarios
  c_wr: cover property (regWr.valid);
  c_pc: cover property (pcWr.valid);
  c_fl: cover property ($fell(flushNop));
endmodule : bcbn_decoder_assertions
`default_nettype wire

// ===== test/bcbn_decoder_bench.sv
// self-checking bench for the bit clear and branch decoder
`timescale 1ns/1ps
`default_nettype none
module bcbn_decoder_bench;
  logic sys_clk, sys_rst, instrValid, negFlag, extEnable, regRdEn;
  logic flushNop, cycleEnd;
  logic [15:0] instrWord;
  logic [20:0] pcIncr;
  logic [3:0] bankSelect;
  logic [11:0] indexBase, regRdAddr;
  logic [7:0] regRdData;
  logic [1:0] phase;
  bcbn_pkg::bcbn_wr_s regWr;
  bcbn_pkg::bcbn_pcw_s pcWr;
  int failures, n_checks;
  bcbn_decoder dut (.sys_clk, .sys_rst, .instrValid, .instrWord, .pcIncr,
    .negFlag, .extEnable, .bankSelect, .indexBase, .regRdData, .regRdAddr,
    .regRdEn, .regWr, .pcWr, .flushNop, .cycleEnd, .phase);
  bcbn_regfile_model u_rf (.regRdAddr, .regRdEn, .regRdData);
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one instruction from accepting Q1 to its closing edge
  task exec(input logic [15:0] w, input logic ew, input logic [11:0] ea,
            input logic ep, input logic [20:0] et);
    logic [7:0] d;
    d = (ea[7:0] ^ ea[11:4] ^ 8'h3c) & ~(8'h01 << w[11:9]);
    repeat (20) if (phase !== 2'h0 || flushNop !== 1'b0) @(negedge sys_clk);
    instrValid = 1'b1;
    instrWord = w;
    @(negedge sys_clk);
    instrValid = 1'b0;
    @(negedge sys_clk);
    chk("rd en", ew, regRdEn);
    if (ew) chk("rd addr", ea, regRdAddr);
    repeat (2) @(negedge sys_clk);
    chk("wr valid", ew, regWr.valid);
    if (ew) chk("wr addr", ea, regWr.addr);
    if (ew) chk("wr data", d, regWr.data);
    chk("pc valid", ep, pcWr.valid);
    chk("nop", ep, flushNop);
    if (ep) chk("target", et, pcWr.target);
    chk("cycle end", 1, cycleEnd);
  endtask : exec
  task t_clear();
    exec(16'h9f3a, 1'b1, 12'h53a, 1'b0, 21'h0);
    exec(16'h9020, 1'b1, 12'h020, 1'b0, 21'h0);
    exec(16'h9280, 1'b1, 12'hf80, 1'b0, 21'h0);
    extEnable = 1'b1;
    exec(16'h945f, 1'b1, 12'h059, 1'b0, 21'h0);
    exec(16'h9660, 1'b1, 12'hf60, 1'b0, 21'h0);
    $display("bit clear test done");
  endtask : t_clear
  // reset in mid instruction, then the next word must be taken
  task t_reset();
    instrValid = 1'b1;
    instrWord = 16'h9f3a;
    @(negedge sys_clk);
    instrValid = 1'b0;
    @(negedge sys_clk);
    chk("rd before reset", 1, regRdEn);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    chk("reset read", 0, regRdEn);
    chk("reset phase", 0, phase);
    chk("reset nop", 0, flushNop);
    sys_rst = 1'b0;
    $display("reset test done");
  endtask : t_reset
  task t_branch();
    negFlag = 1'b1;
    exec(16'he680, 1'b0, 12'h0, 1'b1, 21'h000000);
    // a bit clear offered during the nop cycle must be dropped
    instrValid = 1'b1;
    instrWord = 16'h9f3a;
    repeat (2) @(negedge sys_clk);
    chk("nop read", 0, regRdEn);
    repeat (2) @(negedge sys_clk);
    chk("nop write", 0, regWr.valid);
    chk("nop end", 0, flushNop);
    chk("nop cycle end", 1, cycleEnd);
    pcIncr = 21'h000200;
    exec(16'he67f, 1'b0, 12'h0, 1'b1, 21'h0002fe);
    exec(16'he77f, 1'b0, 12'h0, 1'b0, 21'h0);
    negFlag = 1'b0;
    exec(16'he67f, 1'b0, 12'h0, 1'b0, 21'h0);
    $display("branch test done");
  endtask : t_branch
  initial
  begin
    failures = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    pcIncr = 21'h000100;
    negFlag = 1'b0;
    extEnable = 1'b0;
    bankSelect = 4'h5;
    indexBase = 12'hffa;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_clear();
    t_reset();
    t_branch();
    report_and_stop();
  end
  // watchdog
  initial
  begin
    #5000;
    failures++;
    report_and_stop();
  end
endmodule : bcbn_decoder_bench
bind bcbn_decoder bcbn_decoder_assertions u_chk (.sys_clk, .sys_rst,
  .regRdAddr, .regRdEn, .regWr, .pcWr, .flushNop, .cycleEnd, .phase);
`default_nettype wire

// ===== test/bcbn_regfile_model.sv
// file register array model answering reads
`timescale 1ns/1ps
`default_nettype none
module bcbn_regfile_model (
  input wire logic [11:0] regRdAddr, // read address
  input wire logic regRdEn, // read strobe
  output logic [7:0] regRdData // read data
);
  // pattern per address while read, inverted low address byte when idle
  always_comb
    regRdData = regRdEn ? regRdAddr[7:0] ^ regRdAddr[11:4] ^ 8'h3c
                        : ~regRdAddr[7:0];
endmodule : bcbn_regfile_model
`default_nettype wire
